/* File: core/pin_select.sv */
/*
  Per-pin function and driver selection, purely combinational.
  Assumes the mode inputs are already synchronised to the caller's clock.
*/
`timescale 1ns/1ps
module pin_select #(
  parameter int unsigned WIDTH = 16
) (
  input  wire logic [WIDTH-1:0] direction,
  input  wire logic [WIDTH-1:0] function_sel,
  input  wire logic [WIDTH-1:0] gpio_out,
  input  wire logic [WIDTH-1:0] addr_bus,
  input  wire pinmux_pkg::op_mode_t mode,
  output logic      [WIDTH-1:0] pin_out,
  output logic      [WIDTH-1:0] pin_oe,
  output logic      [WIDTH-1:0] addr_sel
);
  import pinmux_pkg::*;

  function automatic logic addr_chosen(input op_mode_t m, input logic fsel);
    unique case (m)
      MODE_SINGLE_CHIP:  addr_chosen = 1'b0;
      MODE_ROM_DISABLED: addr_chosen = 1'b1;
      default:           addr_chosen = fsel;
    endcase
  endfunction

  for (genvar i = 0; i < WIDTH; i++)
  begin : g_pin
    always_comb
    begin
      addr_sel[i] = addr_chosen(mode, function_sel[i]);
      pin_out[i]  = addr_sel[i] ? addr_bus[i] : gpio_out[i];
      pin_oe[i]   = addr_sel[i] ? 1'b1 : direction[i];
    end
  end
endmodule

/* File: core/pinmux_pkg.sv */
/*
  Constants for the sixteen-pin port direction and function select block.
  Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
*/
package pinmux_pkg;
  localparam int unsigned PIN_COUNT      = 16;
  localparam logic [7:0]  DIRECTION_OFS  = 8'h00;
  localparam logic [7:0]  FUNCTION_OFS   = 8'h04;
  localparam logic [7:0]  STATUS_OFS     = 8'h08;
  localparam logic [15:0] DIRECTION_RST  = 16'h0000;
  localparam logic [15:0] FUNCTION_RST   = 16'h0000;
  localparam int unsigned STAT_SINGLE    = 0;
  localparam int unsigned STAT_NOROM     = 1;
  localparam int unsigned SYNC_STAGES    = 2;
  localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;

  typedef enum logic [1:0] {
    MODE_EXPANDED,
    MODE_SINGLE_CHIP,
    MODE_ROM_DISABLED
  } op_mode_t;
endpackage

/* File: core/port_mux_top.sv */
/*
  Direction and function select registers for a sixteen-pin multiplexed port,
  reached over AHB-Lite, with per-pin output driver selection.
  Assumes resetn is the power-on reset only; other resets and low-power
  states do not reach this block. Mode pins arrive asynchronously.
*/
// The AHB-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ps
module port_mux_top #(
  parameter int unsigned WIDTH = pinmux_pkg::PIN_COUNT
) (
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic      [31:0]      hrdata,
  output logic                  hreadyout,
  output logic                  hresp,
  input  wire logic             single_chip_mode,
  input  wire logic             rom_disabled_mode,
  input  wire logic [WIDTH-1:0] gpio_out,
  input  wire logic [WIDTH-1:0] addr_bus,
  output logic      [WIDTH-1:0] pin_out,
  output logic      [WIDTH-1:0] pin_oe
);
  import pinmux_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] direction;
    logic [WIDTH-1:0] function_sel;
    logic             wr_pend;
    logic [7:0]       wr_addr;
    logic [31:0]      rdata;
    logic [1:0]       sync1;
    logic [1:0]       sync2;
    logic [WIDTH-1:0] pin_out;
    logic [WIDTH-1:0] pin_oe;
  } state_t;

  state_t           st_q;
  state_t           st_d;
  op_mode_t         mode;
  logic [WIDTH-1:0] sel_out;
  logic [WIDTH-1:0] sel_oe;
  logic [WIDTH-1:0] addr_sel;
  logic             take;

  function automatic logic [31:0] read_word(input logic [7:0] a, input state_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (a)
      DIRECTION_OFS: w[WIDTH-1:0] = s.direction;
      FUNCTION_OFS:  w[WIDTH-1:0] = s.function_sel;
      STATUS_OFS:    w[1:0]       = s.sync2;
      default:       w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  // Single chip has priority should both mode pins read high
  always_comb
  begin
    if (st_q.sync2[STAT_SINGLE])
      mode = MODE_SINGLE_CHIP;
    else if (st_q.sync2[STAT_NOROM])
      mode = MODE_ROM_DISABLED;
    else
      mode = MODE_EXPANDED;
  end

  pin_select #(
    .WIDTH (WIDTH)
  ) u_sel (
    .direction    (st_q.direction),
    .function_sel (st_q.function_sel),
    .gpio_out     (gpio_out),
    .addr_bus     (addr_bus),
    .mode         (mode),
    .pin_out      (sel_out),
    .pin_oe       (sel_oe),
    .addr_sel     (addr_sel)
  );

  assign take = hsel && hready && (htrans == HTRANS_NONSEQ);

  always_comb
  begin
    st_d = st_q;
    st_d.sync1 = {rom_disabled_mode, single_chip_mode};
    st_d.sync2 = st_q.sync1;
    st_d.pin_out = sel_out;
    st_d.pin_oe = sel_oe;
    if (st_q.wr_pend)
    begin
      if (st_q.wr_addr == DIRECTION_OFS)
        st_d.direction = hwdata[WIDTH-1:0];
      if (st_q.wr_addr == FUNCTION_OFS)
        st_d.function_sel = hwdata[WIDTH-1:0];
    end
    st_d.wr_pend = take && hwrite;
    if (take)
    begin
      st_d.wr_addr = haddr[7:0];
      st_d.rdata = hwrite ? 32'h0000_0000 : read_word(haddr[7:0], st_q);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      st_q <= '0;
      st_q.direction <= WIDTH'(DIRECTION_RST);
      st_q.function_sel <= WIDTH'(FUNCTION_RST);
    end
    else
      st_q <= st_d;
  end

  assign hrdata    = st_q.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign pin_out   = st_q.pin_out;
  assign pin_oe    = st_q.pin_oe;

  // Pin selection by mode and function
  single_gpio_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    mode == MODE_SINGLE_CHIP |-> addr_sel == '0)
    else $error("address selected in single chip mode");

  single_pins_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    mode == MODE_SINGLE_CHIP
    |=> pin_oe == $past(st_q.direction) && pin_out == $past(gpio_out))
    else $error("pins not general I/O in single chip mode");

  norom_addr_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    mode == MODE_ROM_DISABLED |=> pin_oe == '1 && pin_out == $past(addr_bus))
    else $error("pins not carrying address with ROM disabled");

  fsel_pick_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    mode == MODE_EXPANDED |-> addr_sel == st_q.function_sel)
    else $error("function select not followed");

  dir_gpio_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    mode == MODE_EXPANDED && st_q.function_sel == '0
    |=> pin_oe == $past(st_q.direction) && pin_out == $past(gpio_out))
    else $error("gpio pin does not follow direction");

  addr_drive_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    mode == MODE_EXPANDED
    |=> (pin_oe & $past(st_q.function_sel)) == $past(st_q.function_sel)
    && (pin_out & $past(st_q.function_sel)) == ($past(addr_bus) & $past(st_q.function_sel)))
    else $error("address pin not driven");

  // Register access
  dir_write_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    take && hwrite && haddr[7:0] == DIRECTION_OFS
    ##1 1'b1 |=> st_q.direction == $past(hwdata[WIDTH-1:0]))
    else $error("direction write lost");

  dir_read_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    take && !hwrite && haddr[7:0] == DIRECTION_OFS
    |=> hrdata == 32'($past(st_q.direction)))
    else $error("direction read back wrong");

  fsel_write_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    take && hwrite && haddr[7:0] == FUNCTION_OFS
    ##1 1'b1 |=> st_q.function_sel == $past(hwdata[WIDTH-1:0]))
    else $error("function write lost");

  fsel_read_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    take && !hwrite && haddr[7:0] == FUNCTION_OFS
    |=> hrdata == 32'($past(st_q.function_sel)))
    else $error("function read back wrong");

  // Reset and retention
  reset_clear_a: assert property (@(posedge ref_clk)
    !resetn |=> st_q.direction == '0 && st_q.function_sel == '0)
    else $error("registers not cleared by reset");

  reset_pins_a: assert property (@(posedge ref_clk)
    !resetn |=> pin_oe == '0 && pin_out == '0)
    else $error("pins driving after reset");

  dir_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !st_q.wr_pend
    |=> $stable(st_q.direction) && $stable(st_q.function_sel))
    else $error("register changed without write");

  dir_only_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    st_q.wr_pend && st_q.wr_addr == DIRECTION_OFS
    |=> $stable(st_q.function_sel))
    else $error("function changed by direction write");

  fsel_only_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    st_q.wr_pend && st_q.wr_addr == FUNCTION_OFS
    |=> $stable(st_q.direction))
    else $error("direction changed by function write");

  wrong_ofs_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    st_q.wr_pend && st_q.wr_addr != DIRECTION_OFS && st_q.wr_addr != FUNCTION_OFS
    |=> $stable(st_q.direction) && $stable(st_q.function_sel))
    else $error("register changed by unmapped write");
endmodule

/* File: dv/addr_source.sv */
/* Address bus source standing in for the bus controller.
   Assumes the bench sets the next address on the shared clock. */
`timescale 1ns/1ps
module addr_source (
  input  wire logic        ref_clk,
  input  wire logic [15:0] next_addr,
  output logic      [15:0] addr_bus
);
  // Registered like a real controller output
  always_ff @(posedge ref_clk)
    addr_bus <= next_addr;
endmodule

/* File: dv/port_mux_top_test.sv */
/* Self-checking bench for the port direction and function select block.
   Assumes a single 200 MHz clock and a zero-wait AHB-Lite slave. */
`timescale 1ns/1ps
module port_mux_top_test;
  import pinmux_pkg::*;
  typedef struct {logic [15:0] dir; logic [15:0] fn; logic sc; logic rd;
    logic [15:0] oe; logic [15:0] am;} row_t;
  logic        ref_clk, resetn, hsel, hwrite, sc, rd;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hreadyout, hresp;
  logic [15:0] gv, na, ab, pin_out, pin_oe;
  int          failures, n_compared;
  // Direction, function, single chip, no ROM, expected oe, address-carrying pins
  row_t        rows [5] = '{
    '{16'hA5C3, 16'h0000, 0, 0, 16'hA5C3, 16'h0000},
    '{16'h00FF, 16'hF0F0, 0, 0, 16'hF0FF, 16'hF0F0},
    '{16'h0000, 16'hFFFF, 1, 0, 16'h0000, 16'h0000},
    '{16'h1234, 16'h0000, 0, 1, 16'hFFFF, 16'hFFFF},
    '{16'hFFFF, 16'h8001, 1, 1, 16'hFFFF, 16'h0000}};
  port_mux_top port_mux_top_inst (.ref_clk(ref_clk), .resetn(resetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .single_chip_mode(sc), .rom_disabled_mode(rd), .gpio_out(gv), .addr_bus(ab),
    .pin_out(pin_out), .pin_oe(pin_oe));
  addr_source addr_source_inst (.ref_clk(ref_clk), .next_addr(na), .addr_bus(ab));
  initial
  begin
    ref_clk = 0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic complete_run;
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // Waits for hready at the next edges, bounded
  task automatic rdy;
    int n;
    n = 0;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge ref_clk);
    end
    if (n == 50)
    begin
      failures++;
      complete_run;
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h000000, a};
    rdy;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    r = hrdata;
    chk({31'h0, hresp}, 32'h0, "hresp");
  endtask
  task automatic regs(input logic [15:0] d, input logic [15:0] f);
    bus(0, DIRECTION_OFS, 32'h0);
    chk(r, {16'h0000, d}, "direction");
    bus(0, FUNCTION_OFS, 32'h0);
    chk(r, {16'h0000, f}, "function");
  endtask
  initial
  begin
    {hsel, hwrite, sc, rd, haddr, hwdata, htrans} = '0;
    hsize = 3'h2;
    gv = 16'h3C5A;
    na = 16'h0000;
    failures = 0;
    n_compared = 0;
    resetn = 0;
    repeat (6) @(posedge ref_clk);
    chk(pin_oe, 16'h0000, "oe in reset");
    resetn <= 1;
    regs(DIRECTION_RST, FUNCTION_RST);
    foreach (rows[i])
    begin
      na <= rows[i].fn ^ 16'h5AA5;
      sc <= rows[i].sc;
      rd <= rows[i].rd;
      bus(1, DIRECTION_OFS, {16'hFFFF, rows[i].dir});
      bus(1, FUNCTION_OFS, {16'hFFFF, rows[i].fn});
      repeat (5) @(posedge ref_clk);
      chk(pin_oe, rows[i].oe, "pin_oe");
      chk(pin_out, (rows[i].am & na) | (~rows[i].am & gv), "pin_out");
      regs(rows[i].dir, rows[i].fn);
    end
    bus(0, STATUS_OFS, 32'h0);
    chk(r, {30'h0, rows[4].rd, rows[4].sc}, "status");
    bus(1, 8'h0C, 32'hFFFFFFFF);
    chk(r, 32'h0, "unmapped write");
    bus(0, 8'h0C, 32'h0);
    chk(r, 32'h0, "unmapped read");
    regs(rows[4].dir, rows[4].fn);
    hsel <= 0;
    htrans <= HTRANS_NONSEQ;
    hwrite <= 1;
    haddr <= {24'h000000, DIRECTION_OFS};
    @(posedge ref_clk);
    htrans <= 2'h0;
    hwdata <= 32'h0;
    @(posedge ref_clk);
    regs(rows[4].dir, rows[4].fn);
    resetn <= 0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1;
    regs(DIRECTION_RST, FUNCTION_RST);
    complete_run;
  end
endmodule
